/* File: hdl/ssc_regs.sv */
/*
  Status word with sticky error flags and the device configuration
  registers behind the serial host port, plus the watchdog timer.
  Assumes the command decoder, FIFOs and event sources share the clock;
  only the interrupt input arrives from a pin.
*/
// Operation
// (RULE1) Internal read error response sets status bit 29, cleared by writing one.
// (RULE2) Internal write error response sets status bit 28, cleared by writing one.
// (RULE3) New internal error log entry sets status bit 27, write-one clears.
// (RULE4) Read FIFO underflow after data sets bit 26; write FIFO overflow sets 24.
// (RULE5) Read FIFO empty at first returned word sets bit 25, write-one clears.
// (RULE6) Transfer not ending on a byte boundary sets bit 21, write-one clears.
// (RULE7) Invalid serial opcode sets status bit 20, write-one clears.
// (RULE8) Write continuing after full length sets bit 19, write-one clears.
// (RULE9) Write ending short of requested length sets bit 18, write-one clears.
// (RULE10) Read continuing after all data delivered sets bit 17, write-one clears.
// (RULE11) Read ending short of requested length sets bit 16, write-one clears.
// (RULE12) Bit 5 high while free write FIFO entries reach the threshold.
// (RULE13) Bit 4 high while occupied read FIFO entries reach the threshold.
// (RULE14) Bit 3 shows an internal multiple-transfer access in progress.
// (RULE15) Bit 2 any unmasked internal error; bit 1 any unmasked serial error.
// (RULE16) Bit 0 reflects the interrupt input level, high meaning asserted.
// (RULE17) Undefined addresses in the configuration range read as zero.
// (RULE18) Mode and pin configuration register resets to C8000468.
// (RULE19) Listed bits of 0800, 0820 and 0830 survive sleep; others reset.
// (RULE20) Writing zero leaves a flag; a new event beats a same-cycle clear.
// (RULE21) Watchdog period codes 00 to 11 give 60 ms, 600 ms, 3 s, 6 s.
// (RULE22) Reference clock select zero means 20 MHz, one means 40 MHz.
// (RULE23) Writing one to the kick bit restarts the watchdog, then self-clears.
`timescale 1ns/1ps
`default_nettype none
module ssc_regs #(
  parameter int WD_P0 = ssc_pkg::WD_P0_CYC,
  parameter int WD_P1 = ssc_pkg::WD_P1_CYC,
  parameter int WD_P2 = ssc_pkg::WD_P2_CYC,
  parameter int WD_P3 = ssc_pkg::WD_P3_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire ssc_pkg::ssc_reg_req_t req,
  output logic [31:0] rdata,
  output logic rvalid,
  input wire ssc_pkg::ssc_events_t events,
  input wire ssc_pkg::ssc_live_t live,
  input wire logic [31:0] status_flag_enable,
  input wire logic interrupt_pin,
  input wire logic sleep_enter,
  input wire logic [31:0] device_int_flags_in,
  input wire logic [31:0] core_int_flags_in,
  output logic [31:0] mode_pin_config,
  output logic [31:0] timestamp_prescaler,
  output logic clk_ref_40mhz,
  output logic watchdog_timeout
);
  import ssc_pkg::*;

  // ==========================================================
  // Address decode
  function automatic logic hit(input ssc_reg_req_t r, input logic [15:0] ofs);
    hit = r.addr == ofs;
  endfunction

  // Whole-word offsets only; byte lanes are not decoded
  logic wr_status, wr_mode, wr_pre, wr_ecc0, wr_ecc1, wr_ien, wr_scr;
  always_comb
  begin
    wr_status = req.wr && hit(req, OFS_HOST_PORT_STATUS);
    wr_mode = req.wr && hit(req, OFS_MODE_PIN_CONFIG);
    wr_pre = req.wr && hit(req, OFS_TIMESTAMP_PRESCALER);
    wr_ecc0 = req.wr && hit(req, OFS_ECC_DRV_TEST0);
    wr_ecc1 = req.wr && hit(req, OFS_ECC_DRV_TEST1);
    wr_ien = req.wr && hit(req, OFS_INT_ENABLE_MASK);
    wr_scr = req.wr && hit(req, OFS_SCRATCH_TEST);
  end

  // ==========================================================
  // Interrupt pin synchroniser
  logic s1, s2, s3, int_level;
  logic next_int_level;
  always_comb
  begin
    next_int_level = int_level;
    // Level moves only once two later stages agree, so a runt pulse is not seen
    if (s2 == s3)
      next_int_level = s3;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      int_level <= 1'b0;
    end
    else
    begin
      s1 <= interrupt_pin;
      s2 <= s1;
      s3 <= s2;
      int_level <= next_int_level;
    end
  end

  // ==========================================================
  // Sticky status flags
  logic [31:0] sticky, next_sticky, ev_set;
  always_comb
  begin
    ev_set = '0;
    ev_set[POS_RD_ERR] = events.internal_read_error; // [RULE1]
    ev_set[POS_WR_ERR] = events.internal_write_error; // [RULE2]
    ev_set[POS_ERR_LOG] = events.error_log_write; // [RULE3]
    ev_set[POS_RF_UNDER] = events.read_fifo_underflow; // [RULE4]
    ev_set[POS_WF_OVER] = events.write_fifo_overflow; // [RULE4]
    ev_set[POS_RF_EMPTY] = events.read_fifo_empty; // [RULE5]
    ev_set[POS_END_ERR] = events.end_not_byte; // [RULE6]
    ev_set[POS_BAD_CMD] = events.invalid_command; // [RULE7]
    ev_set[POS_WR_OVER] = events.write_overflow; // [RULE8]
    ev_set[POS_WR_UNDER] = events.write_underflow; // [RULE9]
    ev_set[POS_RD_OVER] = events.read_overflow; // [RULE10]
    ev_set[POS_RD_UNDER] = events.read_underflow; // [RULE11]
    next_sticky = sticky;
    if (wr_status)
      next_sticky = sticky & ~req.wdata; // [RULE20]
    // Set after clear so an event in the clearing cycle is kept
    next_sticky = (next_sticky | ev_set) & STICKY_MASK; // [RULE20]
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      sticky <= RST_STATUS;
    else
      sticky <= next_sticky;
  end

  logic [31:0] status_word, unmasked;
  always_comb
  begin
    unmasked = sticky & status_flag_enable;
    status_word = sticky;
    // Live bits are looked at when read, never stored
    status_word[POS_WF_AVAIL] = live.write_free >= live.write_threshold; // [RULE12]
    status_word[POS_RF_AVAIL] = live.read_used >= live.read_threshold; // [RULE13]
    status_word[POS_ACCESS_ACTIVE] = live.access_active; // [RULE14]
    status_word[POS_INT_ERR_IRQ] = |(unmasked & INTERNAL_ERR_MASK); // [RULE15]
    status_word[POS_SPI_ERR_IRQ] = |(unmasked & SPI_ERR_MASK); // [RULE15]
    status_word[POS_INT_LEVEL] = int_level; // [RULE16]
  end

  // ==========================================================
  // Configuration registers
  logic [31:0] mode, pre, ecc0, ecc1, ien, scr, dflags;
  logic [31:0] next_mode, next_pre, next_ecc0, next_ecc1, next_ien, next_scr, next_dflags;
  logic wd_restart;
  always_comb
  begin
    next_mode = mode;
    next_pre = pre;
    next_ecc0 = ecc0;
    next_ecc1 = ecc1;
    next_ien = ien;
    next_scr = scr;
    // The flag image only mirrors its sources, so sleep trims it for one cycle
    next_dflags = device_int_flags_in;
    // Kick bit reads back set for one cycle only, while the timer restarts
    next_mode[POS_WATCHDOG_KICK] = 1'b0; // [RULE23]
    // Read-only and reserved bits of the mode register keep their value on writes
    if (wr_mode)
      next_mode = (mode & ~WMASK_MODE_PIN_CONFIG) | (req.wdata & WMASK_MODE_PIN_CONFIG);
    if (wr_pre)
      next_pre = req.wdata;
    if (wr_ecc0)
      next_ecc0 = req.wdata;
    if (wr_ecc1)
      next_ecc1 = req.wdata;
    if (wr_ien)
      next_ien = req.wdata;
    if (wr_scr)
      next_scr = req.wdata;
    // Sleep wins over a mode or enable mask write in the same cycle; a kick in that write still restarts the timer
    if (sleep_enter)
    begin
      next_mode = (mode & KEEP_MODE_PIN_CONFIG) | (RST_MODE_PIN_CONFIG & ~KEEP_MODE_PIN_CONFIG); // [RULE19]
      next_dflags = dflags & KEEP_DEVICE_INT_FLAGS; // [RULE19]
      next_ien = (ien & KEEP_INT_ENABLE_MASK) | (RST_INT_ENABLE_MASK & ~KEEP_INT_ENABLE_MASK); // [RULE19]
    end
    wd_restart = wr_mode && req.wdata[POS_WATCHDOG_KICK]; // [RULE23]
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      mode <= RST_MODE_PIN_CONFIG; // [RULE18]
      pre <= RST_TIMESTAMP_PRESCALER;
      ecc0 <= RST_ECC_DRV_TEST;
      ecc1 <= RST_ECC_DRV_TEST;
      ien <= RST_INT_ENABLE_MASK;
      scr <= RST_SCRATCH_TEST;
      dflags <= 32'h00000000;
    end
    else
    begin
      mode <= next_mode;
      pre <= next_pre;
      ecc0 <= next_ecc0;
      ecc1 <= next_ecc1;
      ien <= next_ien;
      scr <= next_scr;
      dflags <= next_dflags;
    end
  end

  // ==========================================================
  // Watchdog timer
  logic [31:0] wd_cnt, next_wd_cnt, wd_limit;
  // Registered expiry pulse keeps the timeout output free of glitches
  logic wd_fire, next_wd_fire;
  always_comb
  begin
    // Period codes map straight to cycle counts of the selected timeout
    unique case (mode[POS_WD_PERIOD_SEL +: 2]) // [RULE21]
      2'h0: wd_limit = WD_P0;
      2'h1: wd_limit = WD_P1;
      2'h2: wd_limit = WD_P2;
      2'h3: wd_limit = WD_P3;
    endcase
    // Held at zero while disabled, so enabling starts a full period
    next_wd_fire = 1'b0;
    next_wd_cnt = wd_cnt + 32'h00000001;
    if (wd_restart || !mode[POS_WD_EN])
      next_wd_cnt = 32'h00000000; // [RULE23]
    else if (wd_cnt >= wd_limit - 32'h00000001)
    begin
      next_wd_cnt = 32'h00000000;
      next_wd_fire = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wd_cnt <= 32'h00000000;
      wd_fire <= 1'b0;
    end
    else
    begin
      wd_cnt <= next_wd_cnt;
      wd_fire <= next_wd_fire;
    end
  end

  // ==========================================================
  // Read path, one cycle latency
  logic [31:0] next_rdata;
  always_comb
  begin
    // Unlisted offsets, reserved holes included, answer zero
    next_rdata = 32'h00000000; // [RULE17]
    // A read and a write in one cycle read the old value
    if (req.rd)
    begin
      unique case (req.addr)
        OFS_HOST_PORT_STATUS: next_rdata = status_word;
        OFS_MODE_PIN_CONFIG: next_rdata = mode;
        OFS_TIMESTAMP_PRESCALER: next_rdata = pre;
        OFS_ECC_DRV_TEST0: next_rdata = ecc0;
        OFS_ECC_DRV_TEST1: next_rdata = ecc1;
        OFS_DEVICE_INT_FLAGS: next_rdata = dflags;
        OFS_CORE_INT_FLAGS: next_rdata = core_int_flags_in;
        OFS_INT_ENABLE_MASK: next_rdata = ien;
        OFS_SCRATCH_TEST: next_rdata = scr;
        default: next_rdata = 32'h00000000; // [RULE17]
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rdata <= 32'h00000000;
      rvalid <= 1'b0;
    end
    else
    begin
      rdata <= next_rdata;
      // Answer comes one cycle after the strobe, for mapped and unmapped offsets alike
      rvalid <= req.rd;
    end
  end

  // Outputs come straight from registers
  assign mode_pin_config = mode;
  assign timestamp_prescaler = pre;
  assign clk_ref_40mhz = mode[POS_CLK_REF]; // [RULE22]
  assign watchdog_timeout = wd_fire;
endmodule
`default_nettype wire

/* File: hdl/ssc_pkg.sv */
/*
  Constants, register map and carrier types for the serial host port
  status and device configuration registers.
  Assumes a 10 MHz core clock and an access port driven by the serial
  command decoder on the same clock.
*/
package ssc_pkg;
  // ==========================================================
  // Clock and timing
  localparam int CLK_KHZ = 10000;
  localparam int WD_P0_MS = 60;
  localparam int WD_P1_MS = 600;
  localparam int WD_P2_MS = 3000;
  localparam int WD_P3_MS = 6000;
  localparam int WD_P0_CYC = WD_P0_MS * CLK_KHZ;
  localparam int WD_P1_CYC = WD_P1_MS * CLK_KHZ;
  localparam int WD_P2_CYC = WD_P2_MS * CLK_KHZ;
  localparam int WD_P3_CYC = WD_P3_MS * CLK_KHZ;

  // ==========================================================
  // Register offsets
  localparam logic [15:0] OFS_HOST_PORT_STATUS = 16'h000C;
  localparam logic [15:0] OFS_MODE_PIN_CONFIG = 16'h0800;
  localparam logic [15:0] OFS_TIMESTAMP_PRESCALER = 16'h0804;
  localparam logic [15:0] OFS_ECC_DRV_TEST0 = 16'h080C;
  localparam logic [15:0] OFS_ECC_DRV_TEST1 = 16'h0810;
  localparam logic [15:0] OFS_DEVICE_INT_FLAGS = 16'h0820;
  localparam logic [15:0] OFS_CORE_INT_FLAGS = 16'h0824;
  localparam logic [15:0] OFS_INT_ENABLE_MASK = 16'h0830;
  localparam logic [15:0] OFS_SCRATCH_TEST = 16'h8080;

  // ==========================================================
  // Reset values, write masks and sleep retention masks
  localparam logic [31:0] RST_MODE_PIN_CONFIG = 32'hC8000468;
  localparam logic [31:0] RST_TIMESTAMP_PRESCALER = 32'h00000002;
  localparam logic [31:0] RST_ECC_DRV_TEST = 32'h00000000;
  localparam logic [31:0] RST_INT_ENABLE_MASK = 32'h0FFFFFFF;
  localparam logic [31:0] RST_SCRATCH_TEST = 32'h00000000;
  localparam logic [31:0] RST_STATUS = 32'h00000000;
  localparam logic [31:0] WMASK_MODE_PIN_CONFIG = 32'hF8EFEFCF;
  localparam logic [31:0] KEEP_MODE_PIN_CONFIG = 32'hC0E8EF03;
  localparam logic [31:0] KEEP_DEVICE_INT_FLAGS = 32'h002C0000;
  localparam logic [31:0] KEEP_INT_ENABLE_MASK = 32'h0000C000;

  // ==========================================================
  // Field positions
  localparam int POS_WD_PERIOD_SEL = 28;
  localparam int POS_CLK_REF = 27;
  localparam int POS_WATCHDOG_KICK = 18;
  localparam int POS_WD_EN = 3;
  localparam int POS_RD_ERR = 29;
  localparam int POS_WR_ERR = 28;
  localparam int POS_ERR_LOG = 27;
  localparam int POS_RF_UNDER = 26;
  localparam int POS_RF_EMPTY = 25;
  localparam int POS_WF_OVER = 24;
  localparam int POS_END_ERR = 21;
  localparam int POS_BAD_CMD = 20;
  localparam int POS_WR_OVER = 19;
  localparam int POS_WR_UNDER = 18;
  localparam int POS_RD_OVER = 17;
  localparam int POS_RD_UNDER = 16;
  localparam int POS_WF_AVAIL = 5;
  localparam int POS_RF_AVAIL = 4;
  localparam int POS_ACCESS_ACTIVE = 3;
  localparam int POS_INT_ERR_IRQ = 2;
  localparam int POS_SPI_ERR_IRQ = 1;
  localparam int POS_INT_LEVEL = 0;
  localparam logic [31:0] STICKY_MASK = 32'h3F3F0000;
  localparam logic [31:0] INTERNAL_ERR_MASK = 32'h3F000000;
  localparam logic [31:0] SPI_ERR_MASK = 32'h003F0000;
  localparam int FIFO_CNT_W = 6;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } ssc_reg_req_t;

  typedef struct packed {
    logic internal_read_error;
    logic internal_write_error;
    logic error_log_write;
    logic read_fifo_underflow;
    logic read_fifo_empty;
    logic write_fifo_overflow;
    logic end_not_byte;
    logic invalid_command;
    logic write_overflow;
    logic write_underflow;
    logic read_overflow;
    logic read_underflow;
  } ssc_events_t;

  typedef struct packed {
    logic [FIFO_CNT_W-1:0] write_free;
    logic [FIFO_CNT_W-1:0] write_threshold;
    logic [FIFO_CNT_W-1:0] read_used;
    logic [FIFO_CNT_W-1:0] read_threshold;
    logic access_active;
  } ssc_live_t;
endpackage

/* File: tb/ssc_host_model.sv */
/* Host model driving the register port with whole-word accesses.
   Assumes the bench calls acc and shares the core clock. */
`timescale 1ns/1ps
`default_nettype none
module ssc_host_model
  import ssc_pkg::*;
(
  input wire logic clock,
  output var ssc_pkg::ssc_reg_req_t req,
  input wire logic [31:0] rdata
);
  // ==========
  // Bus cycle
  initial req = '0;
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d, input int gap,
                     output logic [31:0] q);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clock);
    // Released address and data do not keep their last value
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    // Read data stands for one cycle only, so take it at the edge that samples it
    @(posedge clock);
    q = rdata;
  endtask
endmodule
`default_nettype wire

/* File: tb/ssc_regs_monitor.sv */
/* Checker on the ports of ssc_regs, bound below.
   Assumes one clock and the synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module ssc_regs_monitor
  import ssc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire ssc_pkg::ssc_reg_req_t req,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire ssc_pkg::ssc_events_t events,
  input wire ssc_pkg::ssc_live_t live,
  input wire logic interrupt_pin,
  input wire logic sleep_enter,
  input wire logic [31:0] mode_pin_config,
  input wire logic clk_ref_40mhz
);
  // ==========
  // Sequences
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence st_rd;
    req.rd && req.addr == OFS_HOST_PORT_STATUS;
  endsequence
  sequence clr_rf;
    req.wr && req.addr == OFS_HOST_PORT_STATUS && req.wdata[POS_RF_EMPTY] && !events.read_fifo_empty;
  endsequence
  // ==========
  // Properties
  AST_RESET_CFG:
    assert property (disable iff (1'b0) $fell(rst) |-> mode_pin_config == RST_MODE_PIN_CONFIG && !rvalid)
    else $error("mode register not at reset value");
  AST_RESERVED_ZERO:
    assert property (req.rd && req.addr inside {[16'h0814:16'h081C], [16'h0834:16'h08FC]} |=> rvalid && rdata == '0)
    else $error("reserved address read not zero");
  AST_RD_ERR_SET:
    assert property (events.internal_read_error ##1 st_rd |=> rdata[POS_RD_ERR])
    else $error("read error flag missing");
  AST_BAD_CMD_SET:
    assert property (events.invalid_command ##1 st_rd |=> rdata[POS_BAD_CMD])
    else $error("bad command flag missing");
  AST_W1C:
    assert property (clr_rf ##1 (!events.read_fifo_empty) [*2] ##1 st_rd |=> !rdata[POS_RF_EMPTY])
    else $error("empty flag not cleared");
  AST_INT_LEVEL:
    assert property (interrupt_pin [*6] ##0 st_rd |=> rdata[POS_INT_LEVEL])
    else $error("interrupt level not shown");
  AST_ACTIVE:
    assert property ((live.access_active ##0 st_rd) |=> rdata[POS_ACCESS_ACTIVE])
    else $error("access active not shown");
  AST_WF_AVAIL:
    assert property (st_rd |=> rdata[POS_WF_AVAIL] == ($past(live.write_free) >= $past(live.write_threshold)))
    else $error("write fifo level wrong");
  AST_SLEEP:
    assert property (sleep_enter && !req.wr |=> ((mode_pin_config ^ $past(mode_pin_config)) & KEEP_MODE_PIN_CONFIG) == '0
      && (mode_pin_config & ~KEEP_MODE_PIN_CONFIG) == (RST_MODE_PIN_CONFIG & ~KEEP_MODE_PIN_CONFIG))
    else $error("sleep retention wrong");
  AST_CLK_REF:
    assert property (req.wr && req.addr == OFS_MODE_PIN_CONFIG && !sleep_enter
      |=> clk_ref_40mhz == $past(req.wdata[POS_CLK_REF]))
    else $error("clock reference mismatch");
endmodule
bind ssc_regs ssc_regs_monitor ssc_regs_monitor_i (.clock, .rst, .req, .rdata, .rvalid, .events, .live,
  .interrupt_pin, .sleep_enter, .mode_pin_config, .clk_ref_40mhz);
`default_nettype wire

/* File: tb/test_ssc_regs.sv */
/* Self-checking bench for ssc_regs with the host model.
   Assumes short watchdog periods set at the instance. */
`timescale 1ns/1ps
`default_nettype none
module test_ssc_regs;
  import ssc_pkg::*;
  // ==========
  // Wiring
  logic clock = 1'b0;
  logic rst = 1'b1;
  ssc_reg_req_t req;
  logic [31:0] rdata;
  logic rvalid;
  ssc_events_t ev = '0;
  ssc_live_t live = '{6'd0, 6'd1, 6'd0, 6'd1, 1'b0};
  logic [31:0] en = '0;
  logic ipin = 1'b0;
  logic sleep = 1'b0;
  logic [31:0] dfl = 32'h00A50F00;
  logic [31:0] cfl = 32'h5A0000F1;
  logic [31:0] mpc;
  logic cref;
  logic wdto;
  logic [31:0] tsp;
  int bad_count = 0;
  int tests_run = 0;
  int slow = 0;
  localparam int WDC[4] = '{20, 40, 60, 80};
  localparam logic [31:0] ALL = (RST_MODE_PIN_CONFIG & ~WMASK_MODE_PIN_CONFIG) | (WMASK_MODE_PIN_CONFIG & ~32'h40000);
  always #50 clock = ~clock;
  ssc_regs #(.WD_P0(20), .WD_P1(40), .WD_P2(60), .WD_P3(80)) ssc_regs_i (.clock(clock), .rst(rst), .req(req),
    .rdata(rdata), .rvalid(rvalid), .events(ev), .live(live), .status_flag_enable(en), .interrupt_pin(ipin),
    .sleep_enter(sleep), .device_int_flags_in(dfl), .core_int_flags_in(cfl), .mode_pin_config(mpc),
    .timestamp_prescaler(tsp), .clk_ref_40mhz(cref), .watchdog_timeout(wdto));
  ssc_host_model ssc_host_model_i (.clock(clock), .req(req), .rdata(rdata));
  // ==========
  // Shared tasks
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    ssc_host_model_i.acc(1'b1, a, d, slow, q);
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] q);
    ssc_host_model_i.acc(1'b0, a, '0, slow, q);
  endtask
  task automatic gap(output int n);
    n = 0;
    do
    begin
      @(posedge clock);
      #1 n++;
    end
    while (wdto !== 1'b1 && n < 400);
  endtask
  task automatic wdsel(input int c);
    // Stopping first keeps the counter below any new limit
    wr(OFS_MODE_PIN_CONFIG, RST_MODE_PIN_CONFIG & ~32'h8);
    wr(OFS_MODE_PIN_CONFIG, RST_MODE_PIN_CONFIG | (32'(c) << POS_WD_PERIOD_SEL));
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_map;
    logic [15:0] ra[6] = '{OFS_MODE_PIN_CONFIG, OFS_TIMESTAMP_PRESCALER, OFS_ECC_DRV_TEST0, OFS_ECC_DRV_TEST1,
      OFS_INT_ENABLE_MASK, OFS_SCRATCH_TEST};
    logic [31:0] rv[6] = '{RST_MODE_PIN_CONFIG, RST_TIMESTAMP_PRESCALER, 32'h0, 32'h0, RST_INT_ENABLE_MASK, 32'h0};
    logic [15:0] ua[3] = '{16'h0814, 16'h0834, 16'h08FC};
    logic [31:0] q;
    slow = 3;
    check("ref", cref, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      rd(ra[i], q);
      check("reset", q, rv[i]);
      if (i > 0)
      begin
        wr(ra[i], 32'hA5C35A3C ^ i);
        rd(ra[i], q);
        check("rw", q, 32'hA5C35A3C ^ i);
        if (i == 1)
          check("prescaler port", tsp, 32'hA5C35A3C ^ 1);
      end
    end
    for (int i = 0; i < 3; i++)
    begin
      wr(ua[i], 32'hFFFFFFFF);
      rd(ua[i], q);
      check("reserved", q, 32'h0);
    end
    rd(OFS_CORE_INT_FLAGS, q);
    check("core flags", q, cfl);
    rd(OFS_DEVICE_INT_FLAGS, q);
    check("dev flags", q, dfl);
    slow = 0;
  endtask
  task automatic t_cfg;
    logic [31:0] q;
    wr(OFS_MODE_PIN_CONFIG, 32'hFFFFFFFF);
    rd(OFS_MODE_PIN_CONFIG, q);
    check("mode", q, ALL);
    wr(OFS_MODE_PIN_CONFIG, 32'h0);
    check("ref", cref, 32'h0);
    wr(OFS_MODE_PIN_CONFIG, RST_MODE_PIN_CONFIG);
  endtask
  task automatic t_collide;
    logic [31:0] q;
    fork
      wr(OFS_HOST_PORT_STATUS, STICKY_MASK);
      begin
        @(posedge clock);
        ev <= ssc_events_t'(12'h800);
        @(posedge clock);
        ev <= '0;
      end
    join
    rd(OFS_HOST_PORT_STATUS, q);
    check("collide", q, 32'h20000000);
    wr(OFS_HOST_PORT_STATUS, STICKY_MASK);
  endtask
  task automatic t_sticky;
    logic [31:0] q;
    logic [31:0] f;
    en <= 32'hFFFFFFFF;
    for (int i = 0; i < 12; i++)
    begin
      f = (32'h1 << ((i < 6) ? 16 + i : 18 + i)) | ((i < 6) ? 32'h2 : 32'h4);
      @(posedge clock);
      ev <= ssc_events_t'(12'h001 << i);
      fork
        rd(OFS_HOST_PORT_STATUS, q);
        begin
          @(posedge clock);
          ev <= '0;
        end
      join
      check("set", q, f);
      wr(OFS_HOST_PORT_STATUS, ~f);
      rd(OFS_HOST_PORT_STATUS, q);
      check("kept", q, f);
      wr(OFS_HOST_PORT_STATUS, f);
      rd(OFS_HOST_PORT_STATUS, q);
      check("clear", q, 32'h0);
    end
  endtask
  task automatic t_live;
    logic [31:0] q;
    @(posedge clock);
    live <= '{6'd5, 6'd5, 6'd6, 6'd7, 1'b1};
    rd(OFS_HOST_PORT_STATUS, q);
    check("live", q, 32'h28);
    @(posedge clock);
    live <= '{6'd4, 6'd5, 6'd7, 6'd7, 1'b0};
    rd(OFS_HOST_PORT_STATUS, q);
    check("live", q, 32'h10);
    @(posedge clock);
    ipin <= 1'b1;
    live <= '{6'd0, 6'd1, 6'd0, 6'd1, 1'b0};
    repeat (6) @(posedge clock);
    rd(OFS_HOST_PORT_STATUS, q);
    check("pin", q, 32'h1);
    ipin <= 1'b0;
  endtask
  task automatic t_sleep;
    logic [31:0] q;
    wr(OFS_MODE_PIN_CONFIG, 32'hFFFFFFFF);
    wr(OFS_INT_ENABLE_MASK, 32'h0);
    @(posedge clock);
    sleep <= 1'b1;
    @(posedge clock);
    sleep <= 1'b0;
    rd(OFS_MODE_PIN_CONFIG, q);
    check("sleep", q, (ALL & KEEP_MODE_PIN_CONFIG) | (RST_MODE_PIN_CONFIG & ~KEEP_MODE_PIN_CONFIG));
    rd(OFS_INT_ENABLE_MASK, q);
    check("sleep", q, RST_INT_ENABLE_MASK & ~KEEP_INT_ENABLE_MASK);
  endtask
  task automatic t_wdog;
    int n;
    for (int c = 0; c < 4; c++)
    begin
      wdsel(c);
      gap(n);
      gap(n);
      check("period", 32'(n >= WDC[c] && n <= WDC[c] + 2), 32'h1);
    end
    wdsel(0);
    gap(n);
    repeat (8) @(posedge clock);
    wr(OFS_MODE_PIN_CONFIG, RST_MODE_PIN_CONFIG | 32'h40000);
    gap(n);
    check("kick", 32'(n > 14), 32'h1);
  endtask
  // ==========
  // Sequence and watchdog
  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    t_map();
    t_cfg();
    t_collide();
    t_sticky();
    t_live();
    t_sleep();
    t_wdog();
    conclude();
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    bad_count++;
    conclude();
  end
endmodule
`default_nettype wire
